// ---- src/gpcn_port.sv ----
// GPIO port with direction, latch, pin readback, peripheral takeover,
// two-wire bus direction override and change notification interrupts.
// Assumes pins and peripheral signals are synchronous to clk, and that
// clk is kept running while the device sleeps.
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ps

module gpcn_port #(
   parameter int PIN_W = gpcn_pkg::PIN_N,
   parameter int CN_W = gpcn_pkg::CN_N
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [gpcn_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [gpcn_pkg::BE_W-1:0] byteenable,
   input wire logic [gpcn_pkg::DATA_W-1:0] writedata,
   output logic [gpcn_pkg::DATA_W-1:0] readdata,
   output logic waitrequest,
   input wire logic [PIN_W-1:0] pin_in,
   output gpcn_pkg::gpcn_drive_t pin_drive,
   input wire logic [PIN_W-1:0] periph_en,
   input wire gpcn_pkg::gpcn_drive_t periph_drive,
   input wire logic i2c_mode,
   input wire logic i2c_scl_oe_n,
   input wire logic i2c_sda_oe_n,
   input wire logic sleep,
   input wire logic [CN_W-1:0] change_notify_input,
   output logic [CN_W-1:0] pullup_en,
   output logic irq
);
   import gpcn_pkg::*;

   logic [PIN_W-1:0] dir;
   logic [PIN_W-1:0] latch;
   logic [CN_W-1:0] cn_en;
   logic [CN_W-1:0] cn_stat;
   logic [CN_W-1:0] cn_mask;
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;
   logic [CN_W-1:0] cn_meta;
   logic [CN_W-1:0] cn_sync;
   logic [CN_W-1:0] cn_prev;
   logic [CN_W-1:0] cn_change;
   logic [CN_W-1:0] cn_clear;
   logic [CN_W-1:0] next_cn_stat;
   logic req;
   logic wr_go;
   gpcn_drive_t next_drive;

   // Byte-lane merge of a write into a register of any width up to 32
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                                input logic [DATA_W-1:0] new_v,
                                                input logic [BE_W-1:0] be);
      logic [DATA_W-1:0] res;
      res = old_v;
      for (int i = 0; i < BE_W; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [DATA_W-1:0] widen_pin(input logic [PIN_W-1:0] v);
      logic [DATA_W-1:0] res;
      res = RST_ZERO;
      res[PIN_W-1:0] = v;
      return res;
   endfunction

   function automatic logic [DATA_W-1:0] widen_cn(input logic [CN_W-1:0] v);
      logic [DATA_W-1:0] res;
      res = RST_ZERO;
      res[CN_W-1:0] = v;
      return res;
   endfunction

   // Byte-lane merge narrowed back to the register's own width
   function automatic logic [PIN_W-1:0] merge_pin(input logic [PIN_W-1:0] old_v,
                                                  input logic [DATA_W-1:0] new_v,
                                                  input logic [BE_W-1:0] be);
      logic [DATA_W-1:0] res;
      res = merge(widen_pin(old_v), new_v, be);
      return res[PIN_W-1:0];
   endfunction

   function automatic logic [CN_W-1:0] merge_cn(input logic [CN_W-1:0] old_v,
                                                input logic [DATA_W-1:0] new_v,
                                                input logic [BE_W-1:0] be);
      logic [DATA_W-1:0] res;
      res = merge(widen_cn(old_v), new_v, be);
      return res[CN_W-1:0];
   endfunction

   assign req = read | write;
   // A write lands only at the edge where the master sees waitrequest low
   assign wr_go = write & ~waitrequest;

   // One wait cycle per access: waitrequest drops for exactly one cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         waitrequest <= 1'b1;
      end else if (req && waitrequest) begin
         waitrequest <= 1'b0;
      end else begin
         waitrequest <= 1'b1;
      end
   end

   // Read data captured in the first cycle and held through the answer
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         readdata <= RST_ZERO;
      end else if (read && waitrequest) begin
         unique case (address)
            OFS_DIR: readdata <= widen_pin(dir);
            OFS_PORT: readdata <= widen_pin(pin_sync);
            OFS_LATCH: readdata <= widen_pin(latch);
            OFS_CN_EN: readdata <= widen_cn(cn_en);
            OFS_CN_PU: readdata <= widen_cn(pullup_en);
            OFS_CN_STAT: readdata <= widen_cn(cn_stat);
            OFS_CN_MASK: readdata <= widen_cn(cn_mask);
            default: readdata <= RST_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dir <= RST_DIR[PIN_W-1:0];
      end else if (wr_go && address == OFS_DIR) begin
         dir <= merge_pin(dir, writedata, byteenable);
      end
   end

   // Port and latch writes share the latch
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         latch <= RST_ZERO[PIN_W-1:0];
      end else if (wr_go && (address == OFS_PORT || address == OFS_LATCH)) begin
         latch <= merge_pin(latch, writedata, byteenable);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cn_en <= RST_ZERO[CN_W-1:0];
         pullup_en <= RST_ZERO[CN_W-1:0];
         cn_mask <= RST_ZERO[CN_W-1:0];
      end else if (wr_go) begin
         if (address == OFS_CN_EN) begin
            cn_en <= merge_cn(cn_en, writedata, byteenable);
         end
         if (address == OFS_CN_PU) begin
            pullup_en <= merge_cn(pullup_en, writedata, byteenable);
         end
         if (address == OFS_CN_MASK) begin
            cn_mask <= merge_cn(cn_mask, writedata, byteenable);
         end
      end
   end

   // Two-flop synchronisers; only the second stage is looked at
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pin_meta <= RST_ZERO[PIN_W-1:0];
         pin_sync <= RST_ZERO[PIN_W-1:0];
         cn_meta <= RST_ZERO[CN_W-1:0];
         cn_sync <= RST_ZERO[CN_W-1:0];
      end else begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
         cn_meta <= change_notify_input;
         cn_sync <= cn_meta;
      end
   end

   // Sampling runs on every cycle, sleep does not gate it
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cn_prev <= RST_ZERO[CN_W-1:0];
      end else begin
         cn_prev <= cn_sync;
      end
   end

   // Mismatch against previous sample on enabled inputs
   assign cn_change = (cn_sync ^ cn_prev) & cn_en;
   assign cn_clear = (wr_go && address == OFS_CN_STAT) ?
                     merge_cn(RST_ZERO[CN_W-1:0], writedata, byteenable) : RST_ZERO[CN_W-1:0];
   // Set beats clear so an edge during the clearing write is kept
   assign next_cn_stat = (cn_stat & ~cn_clear) | cn_change;

   // Sticky flags, write one to clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cn_stat <= RST_ZERO[CN_W-1:0];
      end else begin
         cn_stat <= next_cn_stat;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_cn_stat & cn_mask);
      end
   end

   // Pin ownership: bus override, then peripheral, then port
   always_comb begin
      for (int i = 0; i < PIN_W; i++) begin
         next_drive.value[i] = latch[i];
         next_drive.oe_n[i] = dir[i];
         if (periph_en[i]) begin
            next_drive.value[i] = periph_drive.value[i];
            next_drive.oe_n[i] = periph_drive.oe_n[i];
         end
      end
      // Bus owns direction of clock and data pins; open-drain low
      if (i2c_mode) begin
         next_drive.value[SCL_BIT] = 1'b0;
         next_drive.oe_n[SCL_BIT] = i2c_scl_oe_n;
         next_drive.value[SDA_BIT] = 1'b0;
         next_drive.oe_n[SDA_BIT] = i2c_sda_oe_n;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pin_drive.value <= RST_ZERO[PIN_W-1:0];
         pin_drive.oe_n <= RST_DIR[PIN_W-1:0];
      end else begin
         pin_drive <= next_drive;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   dir_drives_pin_a: assert property (
      (!i2c_mode && !periph_en[0]) |=> pin_drive.oe_n[0] == $past(dir[0]))
      else $error("pin 0 enable does not follow direction");

   port_reads_pin_a: assert property (
      (read && waitrequest && address == OFS_PORT) |=>
      (!waitrequest && readdata[PIN_W-1:0] == $past(pin_sync)))
      else $error("port read does not return pin level");

   port_write_latch_a: assert property (
      (wr_go && address == OFS_PORT && byteenable == 4'hf) |=> latch == $past(writedata[PIN_W-1:0]))
      else $error("port write did not reach latch");

   latch_read_back_a: assert property (
      (read && waitrequest && address == OFS_LATCH) |=> readdata[PIN_W-1:0] == $past(latch))
      else $error("latch read wrong");

   periph_owns_pin_a: assert property (
      (periph_en[1] && !i2c_mode) |=> pin_drive.oe_n[1] == $past(periph_drive.oe_n[1]))
      else $error("peripheral did not take the pin");

   bus_owns_dir_a: assert property (
      i2c_mode |=> (pin_drive.oe_n[SCL_BIT] == $past(i2c_scl_oe_n) &&
                    pin_drive.oe_n[SDA_BIT] == $past(i2c_sda_oe_n)))
      else $error("two-wire override lost");

   change_sets_irq_a: assert property (
      (cn_change[0] && cn_mask[0]) |=> irq)
      else $error("enabled change did not raise interrupt");

   sleep_still_detects_a: assert property (
      (sleep && cn_change != '0) |=> (cn_stat & $past(cn_change)) == $past(cn_change))
      else $error("change lost during sleep");

   flag_sticky_a: assert property (
      (cn_stat[0] && !(wr_go && address == OFS_CN_STAT && writedata[0] && byteenable[0])) |=> cn_stat[0])
      else $error("flag dropped without clear");

   wait_one_cycle_a: assert property (
      (req && waitrequest) |=> !waitrequest ##1 waitrequest)
      else $error("bus answer timing wrong");

   pullup_write_a: assert property (
      (wr_go && address == OFS_CN_PU && byteenable == 4'hf) |=> pullup_en == $past(writedata[CN_W-1:0]))
      else $error("pull-up enable write lost");

   cover_change_irq_c: cover property (cn_change[0] ##1 irq);
   cover_sleep_change_c: cover property (sleep && cn_change != '0);
   cover_set_clear_c: cover property (cn_change[0] && cn_clear[0]);
   cover_bus_mode_c: cover property (i2c_mode && periph_en[SCL_BIT]);
endmodule

// ---- src/gpcn_pkg.sv ----
// Package for the GPIO port with change notification: register map,
// reset values and the per-pin drive carrier.
// Assumes a 32-bit Avalon-MM bus with byte addresses on one clock.
package gpcn_pkg;
   localparam int PIN_N = 16;
   localparam int CN_N = 24;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;

   localparam logic [ADDR_W-1:0] OFS_DIR = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_PORT = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_LATCH = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_CN_EN = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_CN_PU = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_CN_STAT = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_CN_MASK = 5'h18;

   // Direction bit one means input, so every pin starts undriven
   localparam logic [DATA_W-1:0] RST_DIR = 32'hffff_ffff;
   localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;

   localparam int SCL_BIT = 2;
   localparam int SDA_BIT = 3;

   typedef struct packed {
      logic [PIN_N-1:0] value;
      logic [PIN_N-1:0] oe_n;
   } gpcn_drive_t;
endpackage

// ---- dv/gpcn_pin_model.sv ----
// Outside world at the port pins: resolves each pin level.
// Assumes the bench sets outside levels for pins the port leaves undriven.
`timescale 1ns/1ps
module gpcn_pin_model
   import gpcn_pkg::*;
(
   input wire gpcn_pkg::gpcn_drive_t drive,
   input wire logic [gpcn_pkg::PIN_N-1:0] ext_val,
   output logic [gpcn_pkg::PIN_N-1:0] level
);
   always_comb begin
      for (int i = 0; i < PIN_N; i++) begin
         level[i] = drive.oe_n[i] ? ext_val[i] : drive.value[i];
      end
   end
endmodule

// ---- dv/gpcn_port_tb_top.sv ----
// Self-checking bench for the port block, one task per scenario.
// Assumes the pin model beside the block and one 250 MHz clock.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module gpcn_port_tb_top;
   import gpcn_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [DATA_W-1:0] writedata = '0;
   logic [BE_W-1:0] be = 4'hf;
   logic [DATA_W-1:0] readdata;
   logic waitrequest;
   logic [PIN_N-1:0] pin_in;
   logic [PIN_N-1:0] ext_val = '0;
   logic [PIN_N-1:0] periph_en = '0;
   gpcn_drive_t pin_drive;
   gpcn_drive_t periph_drive = '0;
   logic i2c_mode = 1'b0;
   logic scl_oe_n = 1'b1;
   logic sda_oe_n = 1'b1;
   logic sleep = 1'b0;
   logic [CN_N-1:0] cn_in = '0;
   logic [CN_N-1:0] pullup_en;
   logic irq;
   logic [DATA_W-1:0] q;
   int n_mismatch = 0;
   int cmp_count = 0;

   always #2 clk = ~clk;

   gpcn_port u_dut(.clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
      .byteenable(be), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .pin_in(pin_in), .pin_drive(pin_drive), .periph_en(periph_en), .periph_drive(periph_drive),
      .i2c_mode(i2c_mode), .i2c_scl_oe_n(scl_oe_n), .i2c_sda_oe_n(sda_oe_n), .sleep(sleep),
      .change_notify_input(cn_in), .pullup_en(pullup_en), .irq(irq));

   gpcn_pin_model u_pins(.drive(pin_drive), .ext_val(ext_val), .level(pin_in));

   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      read <= ~w;
      write <= w;
      writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 20) begin
         n_mismatch++;
         summarize();
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic t_reset();
      `CHK("pullup", 24'h00_0000, pullup_en)
      `CHK("irq", 1'b0, irq)
      bus(1'b0, OFS_DIR, '0);
      `CHK("dir", 32'h0000_ffff, q)
      bus(1'b0, 5'h1c, '0);
      `CHK("unmapped", 32'h0000_0000, q)
      `CHK("oe_n", 16'hffff, pin_drive.oe_n)
   endtask

   task automatic t_latch();
      bus(1'b1, OFS_LATCH, 32'h0000_a5a5);
      bus(1'b1, OFS_DIR, 32'h0000_ff00);
      ext_val <= 16'h3c00;
      cyc(4);
      `CHK("oe_n", 16'hff00, pin_drive.oe_n)
      `CHK("value", 8'ha5, pin_drive.value[7:0])
      bus(1'b0, OFS_PORT, '0);
      `CHK("port", 32'h0000_3ca5, q)
      bus(1'b0, OFS_LATCH, '0);
      `CHK("latch", 32'h0000_a5a5, q)
      bus(1'b1, OFS_PORT, 32'h0000_5a5a);
      bus(1'b0, OFS_LATCH, '0);
      `CHK("latch", 32'h0000_5a5a, q)
      cyc(1);
      `CHK("value", 8'h5a, pin_drive.value[7:0])
      // Only lane 1 written: the low byte must keep its old value
      be <= 4'h2;
      bus(1'b1, OFS_LATCH, 32'h0000_c3c3);
      be <= 4'hf;
      bus(1'b0, OFS_LATCH, '0);
      `CHK("lane", 32'h0000_c35a, q)
   endtask

   task automatic t_takeover();
      periph_en <= 16'h0003;
      periph_drive <= '{value: 16'h0001, oe_n: 16'hfffe};
      cyc(2);
      `CHK("oe_n", 2'b10, pin_drive.oe_n[1:0])
      `CHK("value", 1'b1, pin_drive.value[0])
      // Clock pin also claimed by a peripheral: bus mode must still own it
      periph_en <= 16'h0004;
      i2c_mode <= 1'b1;
      sda_oe_n <= 1'b0;
      cyc(2);
      `CHK("i2c", 2'b01, {pin_drive.oe_n[SDA_BIT], pin_drive.oe_n[SCL_BIT]})
      `CHK("sda", 1'b0, pin_drive.value[SDA_BIT])
      bus(1'b1, OFS_DIR, 32'h0000_ffff);
      scl_oe_n <= 1'b0;
      sda_oe_n <= 1'b1;
      cyc(2);
      `CHK("i2c", 2'b10, {pin_drive.oe_n[SDA_BIT], pin_drive.oe_n[SCL_BIT]})
      i2c_mode <= 1'b0;
      periph_en <= '0;
   endtask

   task automatic t_change();
      bus(1'b1, OFS_CN_EN, 32'h0080_0001);
      bus(1'b1, OFS_CN_MASK, 32'h0000_0001);
      sleep <= 1'b1;
      cn_in <= 24'h80_0002;
      cyc(5);
      `CHK("irq", 1'b0, irq)
      bus(1'b0, OFS_CN_STAT, '0);
      `CHK("stat", 32'h0080_0000, q)
      cn_in <= 24'h80_0003;
      cyc(5);
      `CHK("irq", 1'b1, irq)
      bus(1'b1, OFS_CN_STAT, 32'h0000_0001);
      cyc(2);
      `CHK("irq", 1'b0, irq)
      bus(1'b0, OFS_CN_STAT, '0);
      `CHK("stat", 32'h0080_0000, q)
      bus(1'b1, OFS_CN_PU, 32'h00ff_0f0f);
      cyc(1);
      `CHK("pullup", 24'hff_0f0f, pullup_en)
      bus(1'b0, OFS_CN_EN, '0);
      `CHK("cn_en", 32'h0080_0001, q)
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      cyc(3);
      t_reset();
      t_latch();
      t_takeover();
      t_change();
      summarize();
   end
endmodule
